/* File: hdl/sarrd_top.sv */
// Purpose: frame sequencing and serial readout of a 12-bit SAR converter
// Assumes: select and bit clock come from an outside master, sampled here
// Notes: result word comes from the converter core on result_i
module sarrd_top
#(
   parameter int RES_W = sarrd_pkg::RES_W
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   input wire logic select_n_i,
   input wire logic bit_clk_i,
   input wire logic [RES_W-1:0] result_i,
   output logic serial_data_out_o,
   output logic serial_data_oe_n_o,
   output logic sample_strobe_o,
   output logic acquire_o,
   output logic data_valid_o,
   output logic powered_down_o,
   output logic powered_up_o
);
   if (RES_W != sarrd_pkg::RES_W)
   begin : g_width_check
      $error("RES_W must match the 16-bit frame layout");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic [1:0] sel_sync_reg, sel_sync_next;
   logic [1:0] bck_sync_reg, bck_sync_next;
   logic sel_last_reg, sel_last_next;
   logic bck_last_reg, bck_last_next;
   logic sel_fall, sel_rise, bck_fall, bck_rise;

   always_comb
   begin
      sel_sync_next = {sel_sync_reg[0], select_n_i};
      bck_sync_next = {bck_sync_reg[0], bit_clk_i};
      sel_last_next = sel_sync_reg[1];
      bck_last_next = bck_sync_reg[1];
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         sel_sync_reg <= 2'h3;
         bck_sync_reg <= 2'h0;
         sel_last_reg <= 1'b1;
         bck_last_reg <= 1'b0;
      end
      else if (clk_en_i)
      begin
         sel_sync_reg <= sel_sync_next;
         bck_sync_reg <= bck_sync_next;
         sel_last_reg <= sel_last_next;
         bck_last_reg <= bck_last_next;
      end
   end

   assign sel_fall = sel_last_reg & ~sel_sync_reg[1];
   assign sel_rise = ~sel_last_reg & sel_sync_reg[1];
   assign bck_fall = bck_last_reg & ~bck_sync_reg[1];
   assign bck_rise = ~bck_last_reg & bck_sync_reg[1];

   // ----------------------------------------------------------------
   // Frame sequencer
   // ----------------------------------------------------------------
   sarrd_pkg::sarrd_state_t state_reg, state_next;
   logic [4:0] edge_cnt_reg, edge_cnt_next;
   logic [15:0] shift_reg, shift_next;
   logic sdo_reg, sdo_next;
   logic oe_n_reg, oe_n_next;
   logic strobe_reg, strobe_next;
   logic acq_reg, acq_next;
   logic valid_reg, valid_next;
   logic pd_reg, pd_next;
   logic pup_reg, pup_next;
   logic [5:0] wake_reg, wake_next;

   always_comb
   begin
      state_next = state_reg;
      edge_cnt_next = edge_cnt_reg;
      shift_next = shift_reg;
      sdo_next = sdo_reg;
      oe_n_next = oe_n_reg;
      strobe_next = 1'b0;
      acq_next = acq_reg;
      valid_next = valid_reg;
      pd_next = pd_reg;
      pup_next = pup_reg;
      wake_next = wake_reg;
      if (wake_reg != 6'h00)
      begin
         wake_next = wake_reg - 6'h01;
         pup_next = (wake_reg == 6'h01);
      end
      case (state_reg)
         sarrd_pkg::SARRD_IDLE, sarrd_pkg::SARRD_DOWN:
         begin
            if (sel_fall)
            begin
               state_next = sarrd_pkg::SARRD_CONV;
               edge_cnt_next = sarrd_pkg::EDGE_ZERO;
               strobe_next = ~pd_reg;
               acq_next = 1'b0;
               // Lead zeros, then result, MSB first
               shift_next = {4'h0, result_i};
               sdo_next = 1'b0;
               oe_n_next = 1'b0;
            end
         end
         sarrd_pkg::SARRD_CONV:
         begin
            if (sel_rise)
            begin
               state_next = sarrd_pkg::SARRD_IDLE;
               oe_n_next = 1'b1;
               sdo_next = 1'b0;
               // No acquisition reached: next frame has no data
               if (!acq_reg)
                  valid_next = 1'b0;
               if (!pd_reg && edge_cnt_reg >= sarrd_pkg::EDGE_PD_LO
                   && edge_cnt_reg < sarrd_pkg::EDGE_PD_HI)
               begin
                  pd_next = 1'b1;
                  pup_next = 1'b0;
                  wake_next = 6'h00;
                  valid_next = 1'b0;
                  state_next = sarrd_pkg::SARRD_DOWN;
               end
            end
            else
            begin
               if (bck_fall)
               begin
                  edge_cnt_next = edge_cnt_reg + 5'h01;
                  shift_next = {shift_reg[14:0], 1'b0};
                  sdo_next = shift_reg[14];
                  if (pd_reg && edge_cnt_reg + 5'h01 > sarrd_pkg::EDGE_PD_HI)
                  begin
                     pd_next = 1'b0;
                     wake_next = sarrd_pkg::WAKE_INIT;
                  end
                  if (edge_cnt_reg + 5'h01 == sarrd_pkg::EDGE_END)
                  begin
                     state_next = sarrd_pkg::SARRD_DONE;
                     oe_n_next = 1'b1;
                     sdo_next = 1'b0;
                     valid_next = ~pd_reg;
                  end
               end
               if (bck_rise && edge_cnt_reg >= sarrd_pkg::EDGE_ACQ)
                  acq_next = 1'b1;
            end
         end
         sarrd_pkg::SARRD_DONE:
         begin
            if (bck_rise && edge_cnt_reg >= sarrd_pkg::EDGE_ACQ)
               acq_next = 1'b1;
            if (sel_rise)
               state_next = sarrd_pkg::SARRD_IDLE;
         end
         default:
            state_next = sarrd_pkg::SARRD_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= sarrd_pkg::SARRD_IDLE;
         edge_cnt_reg <= sarrd_pkg::EDGE_ZERO;
         shift_reg <= 16'h0000;
         sdo_reg <= 1'b0;
         oe_n_reg <= 1'b1;
         strobe_reg <= 1'b0;
         acq_reg <= 1'b0;
         valid_reg <= 1'b0;
         pd_reg <= 1'b0;
         pup_reg <= 1'b1;
         wake_reg <= 6'h00;
      end
      else if (clk_en_i)
      begin
         state_reg <= state_next;
         edge_cnt_reg <= edge_cnt_next;
         shift_reg <= shift_next;
         sdo_reg <= sdo_next;
         oe_n_reg <= oe_n_next;
         strobe_reg <= strobe_next;
         acq_reg <= acq_next;
         valid_reg <= valid_next;
         pd_reg <= pd_next;
         pup_reg <= pup_next;
         wake_reg <= wake_next;
      end
   end

   assign serial_data_out_o = sdo_reg;
   assign serial_data_oe_n_o = oe_n_reg;
   assign sample_strobe_o = strobe_reg;
   assign acquire_o = acq_reg;
   assign data_valid_o = valid_reg;
   assign powered_down_o = pd_reg;
   assign powered_up_o = pup_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence frame_start_s;
      clk_en_i && sel_fall && (state_reg != sarrd_pkg::SARRD_CONV);
   endsequence

   frame_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      frame_start_s |=> state_reg == sarrd_pkg::SARRD_CONV)
      else $error("frame did not start on select fall");
   first_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      frame_start_s |=> !oe_n_reg && !sdo_reg)
      else $error("first zero not driven");
   sample_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      strobe_reg |-> $past(sel_fall) && !acq_reg)
      else $error("sample strobe without select fall");
   lead_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !oe_n_reg && edge_cnt_reg < 5'(sarrd_pkg::LEAD_ZEROS) |-> !sdo_reg)
      else $error("lead bit not zero");
   release_end_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state_reg == sarrd_pkg::SARRD_DONE |-> oe_n_reg)
      else $error("output driven after sixteenth edge");
   abort_hiz_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clk_en_i && sel_rise && state_reg == sarrd_pkg::SARRD_CONV
      |=> oe_n_reg && state_reg != sarrd_pkg::SARRD_CONV)
      else $error("abort did not release output");
   acq_point_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(acq_reg) |-> edge_cnt_reg >= sarrd_pkg::EDGE_ACQ)
      else $error("acquisition before thirteenth edge");
   deselect_hiz_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state_reg == sarrd_pkg::SARRD_IDLE |-> oe_n_reg)
      else $error("output driven while idle");
   power_down_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(pd_reg) |-> $past(edge_cnt_reg) >= sarrd_pkg::EDGE_PD_LO
      && $past(edge_cnt_reg) < sarrd_pkg::EDGE_PD_HI)
      else $error("power down outside window");
   early_invalid_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(valid_reg) |-> !$past(acq_reg))
      else $error("valid dropped after acquisition");
endmodule // sarrd_top

/* File: common/sarrd_pkg.sv */
// Purpose: constants for the serial readout of the SAR converter
// Assumes: 40 MHz system clock, link pins sampled by two flip-flops
// Notes: frame is 16 bits, four zeros then 12 result bits
package sarrd_pkg;
   // -----------------------------------------------------------------
   // Frame layout
   // -----------------------------------------------------------------
   localparam int RES_W = 12;
   localparam int FRAME_BITS = 16;
   localparam int LEAD_ZEROS = 4;
   localparam logic [4:0] EDGE_ACQ = 5'h0D;
   localparam logic [4:0] EDGE_END = 5'h10;
   localparam logic [4:0] EDGE_PD_LO = 5'h02;
   localparam logic [4:0] EDGE_PD_HI = 5'h0A;
   localparam logic [4:0] EDGE_ZERO = 5'h00;
   localparam logic [11:0] RESULT_ZERO = 12'h000;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int WAKE_TIME_NS = 1000;
   localparam int WAKE_CYCLES = WAKE_TIME_NS / CLK_PERIOD_NS;
   localparam logic [5:0] WAKE_INIT = 6'(WAKE_CYCLES);
   // -----------------------------------------------------------------
   // Frame states
   // -----------------------------------------------------------------
   typedef enum logic [3:0] {
      SARRD_IDLE = 4'b0001,
      SARRD_CONV = 4'b0010,
      SARRD_DONE = 4'b0100,
      SARRD_DOWN = 4'b1000
   } sarrd_state_t;
endpackage

/* File: verif/sarrd_master.sv */
// Purpose: serial master model driving select and bit clock
// Assumes: bit clock of eight system clocks, idle low
// Notes: reads the data line just before each falling edge
module sarrd_master
(
   input wire logic clk_i,
   input wire logic sdo_i,
   input wire logic oe_n_i,
   output logic select_n_o,
   output logic bit_clk_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic last;
   logic line;
   // Released line shows no stale value
   assign line = oe_n_i ? ~last : sdo_i;
   initial
   begin
      select_n_o = 1'b1;
      bit_clk_o = 1'b0;
      last = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask
   // ------
   // Frame of n falling edges
   // ------
   task automatic frame(input int n, output logic [15:0] word);
      word = 16'h0000;
      select_n_o = 1'b0;
      tick(8);
      for (int i = 0; i < n; i++)
      begin
         bit_clk_o = 1'b1;
         tick(4);
         word = {word[14:0], line};
         last = line;
         bit_clk_o = 1'b0;
         tick(4);
      end
      tick(4);
      select_n_o = 1'b1;
      tick(8);
   endtask
endmodule // sarrd_master

/* File: verif/test_sar_adc_serial_readout.sv */
// Purpose: self-checking bench for the serial readout block
// Assumes: 40 MHz clock, bit clock 200 ns from the master model
// Notes: status checks pack several flags into one compare
module test_sar_adc_serial_readout;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [11:0] result_i = 12'h000;
   logic select_n, bit_clk, serial_data_out, oe_n, strobe, acq, valid, pd, pu;
   logic [15:0] w;
   int n_errors = 0;
   int checks = 0;
   int strobes = 0;
   always #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) if (strobe === 1'b1) strobes++;
   sarrd_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
      .select_n_i(select_n), .bit_clk_i(bit_clk), .result_i(result_i),
      .serial_data_out_o(serial_data_out), .serial_data_oe_n_o(oe_n),
      .sample_strobe_o(strobe), .acquire_o(acq), .data_valid_o(valid),
      .powered_down_o(pd), .powered_up_o(pu));
   sarrd_master m (.clk_i(clk_i), .sdo_i(serial_data_out), .oe_n_i(oe_n),
      .select_n_o(select_n), .bit_clk_o(bit_clk));
   // ------
   // Shared helpers
   // ------
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ------
   // Scenarios
   // ------
   task automatic t_normal();
      int s0;
      logic [11:0] vals [3] = '{12'hA5C, 12'hFFF, 12'h001};
      foreach (vals[i])
      begin
         result_i = vals[i];
         s0 = strobes;
         m.frame(16, w);
         check(w, {4'h0, vals[i]});
         check({oe_n, acq, valid, pd}, 4'b1110);
         check(16'(strobes - s0), 16'h0001);
      end
      $display("test normal frames done");
   endtask
   task automatic t_abort();
      m.frame(13, w);
      check({oe_n, acq, valid, pd}, 4'b1000);
      m.frame(14, w);
      check({oe_n, acq, valid, pd}, 4'b1100);
      $display("test early deselect done");
   endtask
   task automatic t_power();
      int s0;
      int keep [2] = '{1, 10};
      int down [2] = '{2, 9};
      foreach (keep[i])
      begin
         m.frame(keep[i], w);
         check({oe_n, pd, pu}, 3'b101);
      end
      foreach (down[i])
      begin
         m.frame(down[i], w);
         check({oe_n, pd, pu}, 3'b110);
         m.frame(10, w);
         check({oe_n, pd, pu}, 3'b110);
         s0 = strobes;
         m.frame(11, w);
         check({pd, pu, 14'(strobes - s0)}, 16'h0000);
         tick(40);
         check({oe_n, pd, pu}, 3'b101);
      end
      $display("test power down done");
   endtask
   initial
   begin
      #1000000;
      n_errors++;
      conclude();
   end
   initial
   begin
      tick(5);
      rst_n_i = 1'b1;
      tick(4);
      check({oe_n, strobe, acq, valid, pd, pu}, 6'b100001);
      $display("test reset done");
      t_normal();
      t_abort();
      t_power();
      conclude();
   end
endmodule // test_sar_adc_serial_readout
